// >>> rbr_top.sv
// Receive backplane rate select: register slave, word FIFO and serial backplane shifter.
// Notes on behaviour
// - A two-bit read/write speed select field resets to zero and picks the backplane rate.
// - The speed code is decoded by one table with multiplexing off and another with it on.
// - Multiplexing off, code 00: base rate 1.544MHz, clock and sync may be inputs or outputs.
// - Multiplexing off, code 01: 2.048Mbit/s mode clocked by an external 2.048MHz clock.
// - Multiplexing off, code 10: 4.096Mbit/s output timed by an external 4.096MHz clock.
// - Multiplexing off, code 11: 8.192Mbit/s output timed by an external 8.192MHz clock.
// - Multiplexing on, code 00: channels 0 to 3 are bit-interleaved at 12.352MHz on lane 0.
// - In 12.352MHz interleaved mode the frame sync is high only over the framing bit.
// - Multiplexing on, code 01: channels 0 to 3 are bit-interleaved at 16.384MHz on lane 0.
// - In 16.384MHz interleaved mode the frame sync is high only over the framing bit.
// - A separate multiplex enable joins the four channels onto one stream or keeps them apart.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Word FIFO
// ------------------------------------------------------------------
module rbr_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  input  wire logic             i_sys_clk,  // System clock
  input  wire logic             i_rst,      // Asynchronous reset
  input  wire logic             i_clk_en,   // Clock enable
  input  wire logic [WIDTH-1:0] i_data,     // Write word
  input  wire logic             i_valid,    // Write valid
  output logic                  o_ready,    // Not full
  output logic      [WIDTH-1:0] o_data,     // Head word
  output logic                  o_valid,    // Not empty
  input  wire logic             i_ready     // Read accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_ready = cnt_q < (AW+1)'(DEPTH);
  assign o_valid = cnt_q != '0;
  assign o_data  = mem_q[rd_q];

  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && push) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (i_clk_en) begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
module rbr_top #(
  parameter int FIFO_DEPTH = rbr_pkg::FIFO_DEPTH,
  parameter int HALF_CYC   = rbr_pkg::BASE_HALF_CYC
) (
  input  wire logic                       i_sys_clk,              // 200 MHz clock
  input  wire logic                       i_rst,                  // Async reset, high
  input  wire logic                       i_clk_en,               // Freezes state when low
  input  wire logic                       psel,                   // APB select
  input  wire logic                       penable,                // APB enable
  input  wire logic                       pwrite,                 // APB direction
  input  wire logic [rbr_pkg::ADDR_W-1:0] paddr,                  // APB byte address
  input  wire logic [31:0]                pwdata,                 // APB write data
  output logic                            o_pready,               // APB ready
  output logic      [31:0]                o_prdata,               // APB read data
  output logic                            o_pslverr,              // APB error
  input  wire rbr_pkg::rbr_line_word_t    i_line_word,            // Received bits, 4 channels
  input  wire logic                       i_line_valid,           // Line word valid
  output logic                            o_line_ready,           // FIFO has room
  input  wire logic                       i_rx_backplane_clock,   // Backplane clock pin in
  output logic                            o_rx_backplane_clock,   // Backplane clock pin out
  output logic                            o_rx_backplane_clock_oe, // Clock output enable
  input  wire logic                       i_rx_frame_sync,        // Frame sync pin in
  output logic                            o_rx_frame_sync,        // Frame sync pin out
  output logic                            o_rx_frame_sync_oe,     // Sync output enable
  output logic      [3:0]                 o_rx_serial_output      // Serial data, lane per channel; lane 0 only when multiplexed
);
  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  function automatic rbr_pkg::rbr_mode_t decode_mode(input logic mux, input logic [1:0] spd);
    rbr_pkg::rbr_mode_t m;
    m = rbr_pkg::RBR_RSVD;
    if (!mux) begin
      unique case (spd)
        rbr_pkg::SPD_00: m = rbr_pkg::RBR_BASE;
        rbr_pkg::SPD_01: m = rbr_pkg::RBR_HS2;
        rbr_pkg::SPD_10: m = rbr_pkg::RBR_HS4;
        rbr_pkg::SPD_11: m = rbr_pkg::RBR_HS8;
      endcase
    end else begin
      unique case (spd)
        rbr_pkg::SPD_00: m = rbr_pkg::RBR_MUX12;
        rbr_pkg::SPD_01: m = rbr_pkg::RBR_MUX16;
        rbr_pkg::SPD_10: m = rbr_pkg::RBR_RSVD;
        rbr_pkg::SPD_11: m = rbr_pkg::RBR_RSVD;
      endcase
    end
    return m;
  endfunction

  function automatic logic [rbr_pkg::POS_W-1:0] frame_slots(input rbr_pkg::rbr_mode_t m);
    int n;
    n = rbr_pkg::T1_SLOTS;
    unique case (m)
      rbr_pkg::RBR_BASE:  n = rbr_pkg::T1_SLOTS;
      rbr_pkg::RBR_HS2:   n = rbr_pkg::HS2_SLOTS;
      rbr_pkg::RBR_HS4:   n = rbr_pkg::HS4_SLOTS;
      rbr_pkg::RBR_HS8:   n = rbr_pkg::HS8_SLOTS;
      rbr_pkg::RBR_MUX12: n = rbr_pkg::MUX12_SLOTS;
      rbr_pkg::RBR_MUX16: n = rbr_pkg::MUX16_SLOTS;
      rbr_pkg::RBR_RSVD:  n = rbr_pkg::T1_SLOTS;
    endcase
    return rbr_pkg::POS_W'(n);
  endfunction

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [1:0]         speed_q;
  logic               mux_en_q;
  logic               master_q;
  logic               sync_err_q;
  logic               frame_err_q;
  logic               wr_acc;
  logic               rd_acc;
  logic               sel_ctrl;
  logic               sel_dir;
  logic               sel_stat;
  logic               set_sync_err;
  logic               set_frame_err;
  rbr_pkg::rbr_mode_t mode;
  logic               is_mux;
  logic               drive_pins;

  assign mode       = decode_mode(mux_en_q, speed_q);
  assign is_mux     = (mode == rbr_pkg::RBR_MUX12) || (mode == rbr_pkg::RBR_MUX16);
  assign drive_pins = (mode == rbr_pkg::RBR_BASE) && master_q;
  assign sel_ctrl   = paddr == rbr_pkg::RX_IF_CTRL_ADDR;
  assign sel_dir    = paddr == rbr_pkg::RX_IF_DIR_ADDR;
  assign sel_stat   = paddr == rbr_pkg::RX_IF_STAT_ADDR;
  assign wr_acc     = psel && penable && !o_pready && pwrite;
  assign rd_acc     = psel && penable && !o_pready && !pwrite;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else if (i_clk_en) begin
      o_pready  <= psel && penable && !o_pready;
      o_pslverr <= psel && penable && !o_pready && !(sel_ctrl || sel_dir || sel_stat);
      o_prdata  <= 32'h0;
      if (rd_acc && sel_ctrl) begin
        o_prdata <= {29'h0, mux_en_q, speed_q};
      end else if (rd_acc && sel_dir) begin
        o_prdata <= {31'h0, master_q};
      end else if (rd_acc && sel_stat) begin
        o_prdata <= {25'h0, 3'(mode), 1'b0, (mode == rbr_pkg::RBR_RSVD), frame_err_q,
                     sync_err_q};
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      speed_q  <= rbr_pkg::SPEED_RESET;
      mux_en_q <= rbr_pkg::MUX_EN_RESET;
      master_q <= rbr_pkg::DIR_RESET;
    end else if (i_clk_en && wr_acc) begin
      if (sel_ctrl) begin
        speed_q  <= pwdata[rbr_pkg::SPEED_LSB +: 2];
        mux_en_q <= pwdata[rbr_pkg::MUX_EN_BIT];
      end
      if (sel_dir) begin
        master_q <= pwdata[rbr_pkg::DIR_MASTER_BIT];
      end
    end
  end

  // Status flags clear on a write of one; a new event in the same cycle wins.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_err_q  <= 1'b0;
      frame_err_q <= 1'b0;
    end else if (i_clk_en) begin
      if (set_sync_err) begin
        sync_err_q <= 1'b1;
      end else if (wr_acc && sel_stat && pwdata[rbr_pkg::STAT_SYNC_ERR]) begin
        sync_err_q <= 1'b0;
      end
      if (set_frame_err) begin
        frame_err_q <= 1'b1;
      end else if (wr_acc && sel_stat && pwdata[rbr_pkg::STAT_FRAME_ERR]) begin
        frame_err_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Pin synchronisers and bit clock
  // ------------------------------------------------------------------
  logic [1:0] clk_sync_q;
  logic [1:0] fs_sync_q;
  logic       clk_prev_q;
  logic [7:0] div_q;
  logic       slave_edge;
  logic       master_edge;
  logic       bit_edge;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_sync_q <= 2'h0;
      fs_sync_q  <= 2'h0;
      clk_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      clk_sync_q <= {clk_sync_q[0], i_rx_backplane_clock};
      fs_sync_q  <= {fs_sync_q[0], i_rx_frame_sync};
      clk_prev_q <= clk_sync_q[1];
    end
  end

  // Base-rate master clock comes from a divider; fractional period error is accepted.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q                <= 8'h0;
      o_rx_backplane_clock <= 1'b0;
    end else if (i_clk_en) begin
      if (!drive_pins || div_q == 8'(HALF_CYC - 1)) begin
        div_q <= 8'h0;
      end else begin
        div_q <= div_q + 8'h1;
      end
      if (drive_pins && div_q == 8'(HALF_CYC - 1)) begin
        o_rx_backplane_clock <= !o_rx_backplane_clock;
      end else if (!drive_pins) begin
        o_rx_backplane_clock <= 1'b0;
      end
    end
  end

  assign slave_edge  = clk_sync_q[1] && !clk_prev_q;
  assign master_edge = drive_pins && (div_q == 8'(HALF_CYC - 1)) && !o_rx_backplane_clock;
  assign bit_edge    = drive_pins ? master_edge : slave_edge;

  // ------------------------------------------------------------------
  // FIFO and shifter
  // ------------------------------------------------------------------
  rbr_pkg::rbr_line_word_t       head;
  rbr_pkg::rbr_line_word_t       hold_q;
  logic                          head_valid;
  logic                          pop;
  logic [1:0]                    lane_q;
  logic [rbr_pkg::POS_W-1:0]     pos_q;
  logic [rbr_pkg::POS_W-1:0]     last_pos;
  logic                          sync_in;
  logic                          load;

  rbr_fifo #(
    .WIDTH ($bits(rbr_pkg::rbr_line_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_data    (i_line_word),
    .i_valid   (i_line_valid),
    .o_ready   (o_line_ready),
    .o_data    (head),
    .o_valid   (head_valid),
    .i_ready   (pop)
  );

  assign last_pos = frame_slots(mode) - 1'b1;
  assign sync_in  = !drive_pins && fs_sync_q[1];
  // A sync slot always starts a word, so a lane count left over from an earlier mode
  // cannot swallow the first word of a new frame.
  assign load     = bit_edge && (sync_in || !is_mux || lane_q == 2'h0)
                    && (mode != rbr_pkg::RBR_RSVD);
  assign pop      = i_clk_en && load && head_valid;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lane_q <= 2'h0;
      pos_q  <= '0;
      hold_q <= '0;
    end else if (i_clk_en && bit_edge) begin
      if (sync_in) begin
        pos_q  <= rbr_pkg::POS_W'(1);
        lane_q <= is_mux ? 2'h1 : 2'h0;
      end else begin
        pos_q  <= (pos_q >= last_pos) ? '0 : pos_q + 1'b1;
        lane_q <= is_mux ? lane_q + 2'h1 : 2'h0;
      end
      if (load) begin
        hold_q <= head_valid ? head : '0;
      end
    end
  end

  // Lane 0 carries the interleaved stream; the others idle low in multiplexed modes.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_serial_output <= 4'h0;
    end else if (i_clk_en && bit_edge) begin
      if (mode == rbr_pkg::RBR_RSVD) begin
        o_rx_serial_output <= 4'h0;
      end else if (is_mux) begin
        o_rx_serial_output <= {3'h0, load ? head_valid && head.ch[0]
                                          : hold_q.ch[lane_q]};
      end else begin
        o_rx_serial_output <= load && head_valid ? head.ch : 4'h0;
      end
    end
  end

  // Sync must coincide with the framing bit; a line word out of step is flagged too.
  assign set_sync_err  = bit_edge && sync_in && (pos_q != '0) && (pos_q <= last_pos)
                         && (lane_q == 2'h0) && pos_q != rbr_pkg::POS_W'(1);
  assign set_frame_err = pop && (pos_q == '0) && !head.framing;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_frame_sync         <= 1'b0;
      o_rx_frame_sync_oe      <= 1'b0;
      o_rx_backplane_clock_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_rx_backplane_clock_oe <= drive_pins;
      o_rx_frame_sync_oe      <= drive_pins;
      if (bit_edge) begin
        o_rx_frame_sync <= drive_pins && (pos_q == '0);
      end
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_ctrl_write;
    i_clk_en && wr_acc && sel_ctrl;
  endsequence

  sequence s_mux_load;
    i_clk_en && load && is_mux && !sync_in;
  endsequence

  a_speed_reg_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !(i_clk_en && wr_acc && sel_ctrl) |=> $stable(speed_q))
    else $error("speed select changed without a write");

  a_speed_reg_load: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_ctrl_write |=> speed_q == $past(pwdata[1:0]) && mux_en_q == $past(pwdata[2]))
    else $error("control write not stored");

  a_mux_decode_sel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    mux_en_q && speed_q == 2'h0 |-> mode == rbr_pkg::RBR_MUX12)
    else $error("multiplexed code 00 decoded wrongly");

  a_base_pins_dir: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_clk_en && speed_q == 2'h0 && !mux_en_q && master_q |=> o_rx_backplane_clock_oe)
    else $error("base-rate master does not drive clock");

  a_hs2_pins_input: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_clk_en && speed_q == 2'h1 && !mux_en_q |=> !o_rx_backplane_clock_oe && !o_rx_frame_sync_oe)
    else $error("2.048 mode drives backplane pins");

  a_hs4_pins_input: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_clk_en && speed_q == 2'h2 && !mux_en_q |=> !o_rx_backplane_clock_oe)
    else $error("4.096 mode drives backplane clock");

  a_hs8_pins_input: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_clk_en && speed_q == 2'h3 && !mux_en_q |=> !o_rx_frame_sync_oe)
    else $error("8.192 mode drives frame sync");

  a_lane_order_seq: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_mux_load |=> lane_q == 2'h1)
    else $error("interleave did not advance to channel 1");

  a_mux_out_ch0: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (s_mux_load and head_valid) |=> o_rx_serial_output == {3'h0, $past(head.ch[0])})
    else $error("interleaved stream does not start with channel 0");

  a_sync_align_pos: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_clk_en && bit_edge && sync_in |=> pos_q == rbr_pkg::POS_W'(1))
    else $error("frame sync did not realign framing slot");

  a_sep_lanes_out: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_clk_en && load && head_valid && !is_mux |=> o_rx_serial_output == $past(head.ch))
    else $error("separate channels not presented");
endmodule

// >>> rbr_pkg.sv
// Shared constants, field layouts and carrier types for the receive backplane rate select block.
package rbr_pkg;

  // ------------------------------------------------------------------
  // Register map (indices; byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [11:0] RX_IF_CTRL_IDX  = 12'h122;
  localparam logic [11:0] RX_IF_DIR_IDX   = 12'h123;
  localparam logic [11:0] RX_IF_STAT_IDX  = 12'h124;
  localparam logic [13:0] RX_IF_CTRL_ADDR = {RX_IF_CTRL_IDX, 2'b00};
  localparam logic [13:0] RX_IF_DIR_ADDR  = {RX_IF_DIR_IDX, 2'b00};
  localparam logic [13:0] RX_IF_STAT_ADDR = {RX_IF_STAT_IDX, 2'b00};
  localparam int          ADDR_W          = 14;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int         SPEED_LSB       = 0;
  localparam int         MUX_EN_BIT      = 2;
  localparam int         DIR_MASTER_BIT  = 0;
  localparam int         STAT_SYNC_ERR   = 0;
  localparam int         STAT_FRAME_ERR  = 1;
  localparam int         STAT_RESERVED   = 2;
  localparam int         STAT_MODE_LSB   = 4;
  localparam logic [1:0] SPEED_RESET     = 2'h0;
  localparam logic       MUX_EN_RESET    = 1'b0;
  localparam logic       DIR_RESET       = 1'b0;

  // ------------------------------------------------------------------
  // Speed select codes
  // ------------------------------------------------------------------
  localparam logic [1:0] SPD_00 = 2'h0;
  localparam logic [1:0] SPD_01 = 2'h1;
  localparam logic [1:0] SPD_10 = 2'h2;
  localparam logic [1:0] SPD_11 = 2'h3;

  // ------------------------------------------------------------------
  // Timing and framing
  // ------------------------------------------------------------------
  localparam int SYS_CLK_HZ    = 200_000_000;
  localparam int BASE_CLK_HZ   = 1_544_000;
  localparam int BASE_HALF_CYC = SYS_CLK_HZ / (2 * BASE_CLK_HZ);
  localparam int LANES         = 4;
  localparam int T1_SLOTS      = 193;
  localparam int HS2_SLOTS     = 256;
  localparam int HS4_SLOTS     = 512;
  localparam int HS8_SLOTS     = 1024;
  localparam int MUX12_SLOTS   = 772;
  localparam int MUX16_SLOTS   = 2048;
  localparam int POS_W         = 11;
  localparam int FIFO_DEPTH    = 4;

  typedef enum logic [2:0] {
    RBR_BASE, RBR_HS2, RBR_HS4, RBR_HS8, RBR_MUX12, RBR_MUX16, RBR_RSVD
  } rbr_mode_t;

  typedef struct packed {
    logic       framing;
    logic [3:0] ch;
  } rbr_line_word_t;

endpackage

// >>> rbr_bp_partner.sv
// Behavioural backplane partner that drives the receive clock and frame sync.
`timescale 1ns/1ps
module rbr_bp_partner (
  input  wire logic i_run,   // Run a frame
  input  wire logic i_slow,  // Double the bit period
  output logic      o_clk,   // Backplane clock
  output logic      o_sync   // Frame sync, active high
);
  initial begin
    o_clk  = 1'b0;
    o_sync = 1'b0;
  end
  // The clock stands low between frames; sync covers the first slot only.
  always begin
    wait (i_run);
    #11 o_sync = 1'b1;
    while (i_run) begin
      #(i_slow ? 80 : 40) o_clk = 1'b1;
      #(i_slow ? 80 : 40) o_clk = 1'b0;
      o_sync = 1'b0;
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for the receive backplane rate select block.
`timescale 1ns/1ps
module tb_top;
  localparam int HALF = 4;
  typedef struct packed {logic [2:0] ctrl; logic [3:0] stat;} rbr_row_t;
  rbr_row_t                rows [8] = '{7'h00, 7'h12, 7'h24, 7'h36, 7'h48, 7'h5a, 7'h6d, 7'h7d};
  logic [4:0]              words [4] = '{5'h13, 5'h05, 5'h0c, 5'h0a};
  logic                    clk, rst, psel, penable, pwrite, run, slow, lvalid, err, clk_en;
  logic                    pready, pslverr, lready, bclk_o, bclk_oe, sync_o, sync_oe, p_clk, p_sync;
  logic [13:0]             paddr;
  logic [31:0]             pwdata, rdata, prdata;
  logic [3:0]              ser;
  rbr_pkg::rbr_line_word_t lword;
  int                      err_count = 0;
  int                      n_compared = 0;
  int                      c;
  wire                     bp_clk = bclk_oe ? bclk_o : p_clk;
  wire                     bp_sync = sync_oe ? sync_o : p_sync;

  rbr_top #(.HALF_CYC(HALF)) i_rbr_top (
    .i_sys_clk(clk), .i_rst(rst), .i_clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_line_word(lword), .i_line_valid(lvalid), .o_line_ready(lready),
    .i_rx_backplane_clock(bp_clk), .o_rx_backplane_clock(bclk_o),
    .o_rx_backplane_clock_oe(bclk_oe), .i_rx_frame_sync(bp_sync), .o_rx_frame_sync(sync_o),
    .o_rx_frame_sync_oe(sync_oe), .o_rx_serial_output(ser));
  rbr_bp_partner i_rbr_bp_partner (.i_run(run), .i_slow(slow), .o_clk(p_clk), .o_sync(p_sync));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // An idle cycle before each setup keeps every signal to one assignment per edge.
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    @(posedge clk) psel <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    // Read right after the edge, pready still shows the value sampled at that edge.
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Valid stays up after the word is taken; the caller lowers it after the last word.
  task automatic push(input logic [4:0] w);
    lvalid <= 1'b1;
    lword  <= w;
    do @(negedge clk); while (lready !== 1'b1);
    @(posedge clk);
  endtask

  task automatic slot_check(input string name, input logic [3:0] exp);
    @(posedge p_clk);
    @(negedge p_clk);
    check(name, 32'(ser), 32'(exp));
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #50us;
    err_count++;
    results();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    {rst, psel, penable, pwrite, lvalid, run, slow} = 7'h40;
    paddr  = 14'h0;
    pwdata = 32'h0;
    lword  = 5'h0;
    clk_en = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, rbr_pkg::RX_IF_CTRL_ADDR, 32'h0);
    check("ctrl reset", rdata, 32'h0);
    apb(1'b1, 14'h494, 32'h7);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rdata, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      apb(1'b1, rbr_pkg::RX_IF_CTRL_ADDR, 32'(rows[i].ctrl));
      apb(1'b0, rbr_pkg::RX_IF_CTRL_ADDR, 32'h0);
      check("ctrl readback", rdata, 32'(rows[i].ctrl));
      apb(1'b0, rbr_pkg::RX_IF_STAT_ADDR, 32'h0);
      check("mode", 32'({rdata[6:4], rdata[2]}), 32'(rows[i].stat));
    end
    $display("test decode done");
    apb(1'b1, rbr_pkg::RX_IF_CTRL_ADDR, 32'h4);
    push(5'h1a);
    push(5'h06);
    lvalid <= 1'b0;
    run    <= 1'b1;
    for (int k = 0; k < 8; k++) slot_check("mux lane", {3'b0, c_bit(k)});
    @(posedge clk) run <= 1'b0;
    @(negedge p_clk);
    $display("test interleave done");
    apb(1'b1, rbr_pkg::RX_IF_CTRL_ADDR, 32'h1);
    foreach (words[k]) push(words[k]);
    lvalid <= 1'b0;
    @(negedge clk) check("fifo full", 32'(lready), 32'h0);
    @(posedge clk) slow <= 1'b1;
    run <= 1'b1;
    foreach (words[k]) slot_check("lanes", words[k][3:0]);
    check("pin enables", 32'({bclk_oe, sync_oe}), 32'h0);
    check("fifo drained", 32'(lready), 32'h1);
    @(posedge clk) run <= 1'b0;
    @(negedge p_clk);
    $display("test high speed done");
    apb(1'b1, rbr_pkg::RX_IF_DIR_ADDR, 32'h1);
    apb(1'b1, rbr_pkg::RX_IF_CTRL_ADDR, 32'h0);
    @(negedge clk) check("master enables", 32'({bclk_oe, sync_oe}), 32'h3);
    do @(negedge clk); while (bclk_o !== 1'b1);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (bclk_o === 1'b1);
    check("half period", c, HALF);
    do @(negedge clk); while (sync_o !== 1'b1);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (sync_o === 1'b1);
    check("sync width", c, 2 * HALF);
    do @(negedge clk); while (bclk_o !== 1'b1);
    @(posedge clk) clk_en <= 1'b0;
    repeat (20) @(negedge clk);
    check("frozen clock", 32'(bclk_o), 32'h1);
    @(posedge clk) clk_en <= 1'b1;
    @(posedge clk) rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk) check("enables after reset", 32'({bclk_oe, sync_oe}), 32'h0);
    apb(1'b0, rbr_pkg::RX_IF_CTRL_ADDR, 32'h0);
    check("ctrl after reset", rdata, 32'h0);
    $display("test base rate done");
    results();
  end

  // Interleaved order: word A channels 0 to 3, then word B.
  function automatic logic c_bit(input int k);
    logic [7:0] stream;
    stream = 8'h6a;
    return stream[k];
  endfunction
endmodule
